// ===== verilog/port_change_interrupt.sv
`timescale 1ns/1ns

// Notes on behaviour
// R1: Four upper pins share one change flag
// R2: Port read recaptures reference, ends mismatch
// R3: Pin high at read flags later fall
// R4: Pin low at read flags later rise
// R5: Software reads port, then clears flag
// R6: Both-edge sources hold levels past service
// R7: Pulse widths bounded by service routine times
// R8: Rising-only software discards low-level interrupts
// R9: Software XORs reading against saved snapshot
// R10: Only input-configured pins join comparison
// R11: Enabled change wakes core; vector if global
// R12: Synchronise pins; mismatch sets flag each cycle
// R13: Flag sticky; clear during mismatch re-sets
module port_change_interrupt #(
    parameter int PIN_COUNT = port_change_pkg::CHANGE_PIN_COUNT
) (
    input  wire logic                 clk_i,
    input  wire logic                 rst_n_i,
    input  wire logic [7:0]           port_pins_i,
    input  wire logic [7:0]           port_dir_in_i,
    input  wire logic                 port_read_i,
    input  wire logic                 flag_clear_i,
    input  wire logic                 port_change_irq_enable_i,
    input  wire logic                 global_irq_enable_i,
    input  wire logic                 sleeping_i,
    output logic      [7:0]           change_port_o,
    output logic                      port_change_flag_o,
    output logic                      wake_o,
    output logic                      vector_jump_o,
    output logic      [12:0]          vector_addr_o
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [7:0]            sync1;
        logic [7:0]            sync2;
        logic [PIN_COUNT-1:0]  previous_port_snapshot;
        logic [7:0]            change_port;
        logic                  flag;
        logic                  wake;
        logic                  vector_jump;
        logic [12:0]           vector_addr;
    } state_t;

    state_t state_reg;
    state_t state_next;

    logic [PIN_COUNT-1:0] live_pins;
    logic [PIN_COUNT-1:0] input_mask;
    logic [PIN_COUNT-1:0] mismatch;
    logic                 change_any;

    // Top change pin, used by the edge direction checks
    localparam int        TOP_PIN = PIN_COUNT - 1;

    // ****************************************
    // Synchronised compare
    // ****************************************
    assign live_pins  = state_reg.sync2[port_change_pkg::CHANGE_PIN_LSB +: PIN_COUNT];
    assign input_mask = port_dir_in_i[port_change_pkg::CHANGE_PIN_LSB +: PIN_COUNT];
    // Output-driven pins are masked so they can never raise the flag
    assign mismatch   = (live_pins ^ state_reg.previous_port_snapshot) & input_mask; // R10 R12
    assign change_any = |mismatch; // R1

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        state_next       = state_reg;
        // Raw pins go through two stages before anything reads them
        state_next.sync1 = port_pins_i; // R12
        state_next.sync2 = state_reg.sync1;
        state_next.wake        = 1'b0;
        state_next.vector_jump = 1'b0;
        if (port_read_i) begin
            // Capturing the present level decides the next edge direction
            state_next.previous_port_snapshot = live_pins; // R2 R3 R4
            state_next.change_port            = state_reg.sync2;
        end
        // Set wins over clear, so a clear during mismatch is undone
        if (change_any) begin
            state_next.flag = 1'b1; // R12 R13
        end else if (flag_clear_i) begin
            state_next.flag = 1'b0; // R13
        end
        if (state_reg.flag && port_change_irq_enable_i && sleeping_i) begin
            state_next.wake        = 1'b1; // R11
            state_next.vector_jump = global_irq_enable_i; // R11
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_reg.sync1                  <= port_change_pkg::PORT_RESET;
            state_reg.sync2                  <= port_change_pkg::PORT_RESET;
            state_reg.previous_port_snapshot <= PIN_COUNT'(port_change_pkg::SNAPSHOT_RESET);
            state_reg.change_port            <= port_change_pkg::PORT_RESET;
            state_reg.flag                   <= 1'b0;
            state_reg.wake                   <= 1'b0;
            state_reg.vector_jump            <= 1'b0;
            state_reg.vector_addr            <= port_change_pkg::IRQ_VECTOR;
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Vector address is held in a flop so that every output is registered
    assign change_port_o      = state_reg.change_port;
    assign port_change_flag_o = state_reg.flag;
    assign wake_o             = state_reg.wake;
    assign vector_jump_o      = state_reg.vector_jump;
    assign vector_addr_o      = state_reg.vector_addr;

    // ****************************************
    // Checks
    // ****************************************
    sequence read_done_s;
        port_read_i ##1 1'b1;
    endsequence

    AST_MISMATCH_SETS: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R12
        change_any |=> port_change_flag_o)
        else $error("Mismatch did not set change flag");

    AST_CLEAR_DURING_MISMATCH: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R13
        (flag_clear_i && change_any) |=> port_change_flag_o)
        else $error("Clear during mismatch dropped flag");

    AST_CLEAR_WORKS: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R13
        (flag_clear_i && !change_any) |=> !port_change_flag_o)
        else $error("Clear without mismatch ignored");

    AST_STICKY: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R13
        (port_change_flag_o && !flag_clear_i) |=> port_change_flag_o)
        else $error("Flag dropped without clear");

    AST_READ_ENDS_MISMATCH: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R2
        (port_read_i && $stable(live_pins)) ##0 read_done_s |-> (mismatch == '0) || !$stable(live_pins))
        else $error("Port read did not end mismatch");

    AST_SNAPSHOT_CAPTURE: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R3
        port_read_i |=> (state_reg.previous_port_snapshot == $past(live_pins)))
        else $error("Snapshot not captured on read");

    AST_OUTPUT_PINS_QUIET: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R10
        (input_mask == '0 && !port_change_flag_o && !change_any) |=> !port_change_flag_o)
        else $error("Output pins raised change flag");

    AST_WAKE: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R11
        (port_change_flag_o && port_change_irq_enable_i && sleeping_i) |=>
        (wake_o && vector_jump_o == $past(global_irq_enable_i)))
        else $error("Wake or vector choice wrong");

    // ****************************************
    // Pipeline and output checks
    // ****************************************
    AST_SYNC_CHAIN: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R12
        $past(rst_n_i) |=> (state_reg.sync2 == $past(port_pins_i, 2)))
        else $error("Pin synchroniser delay wrong");

    AST_READ_CAPTURES_PORT: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R2
        port_read_i |=> (change_port_o == $past(state_reg.sync2)))
        else $error("Port read value not captured");

    AST_FLAG_RISE_CAUSE: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R12
        $rose(port_change_flag_o) |-> $past(change_any))
        else $error("Flag rose without mismatch");

    AST_NO_WAKE_AWAKE: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R11
        !sleeping_i |=> !wake_o)
        else $error("Wake while core awake");

    AST_NO_WAKE_DISABLED: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R11
        !port_change_irq_enable_i |=> !wake_o)
        else $error("Wake with change enable off");

    AST_NO_WAKE_WITHOUT_FLAG: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R11
        !port_change_flag_o |=> !wake_o)
        else $error("Wake without change flag");

    AST_JUMP_NEEDS_WAKE: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R11
        vector_jump_o |-> wake_o)
        else $error("Vector jump without wake");

    // ****************************************
    // Edge direction and service checks
    // ****************************************
    // A read one cycle before the synchronised edge is the narrowest case
    sequence top_high_at_read_s;
        port_read_i && live_pins[TOP_PIN] && input_mask[TOP_PIN];
    endsequence

    sequence top_low_at_read_s;
        port_read_i && !live_pins[TOP_PIN] && input_mask[TOP_PIN];
    endsequence

    sequence top_fell_s;
        !live_pins[TOP_PIN] && input_mask[TOP_PIN];
    endsequence

    sequence top_rose_s;
        live_pins[TOP_PIN] && input_mask[TOP_PIN];
    endsequence

    AST_FALL_AFTER_HIGH_READ: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R3
        top_high_at_read_s ##1 top_fell_s |=> port_change_flag_o)
        else $error("Fall after high read not flagged");

    AST_RISE_AFTER_LOW_READ: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R4
        top_low_at_read_s ##1 top_rose_s |=> port_change_flag_o)
        else $error("Rise after low read not flagged");

    sequence read_then_clear_s;
        port_read_i ##1 (flag_clear_i && !change_any);
    endsequence

    AST_SERVICE_CLEARS: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R2 R13
        read_then_clear_s |=> !port_change_flag_o)
        else $error("Read then clear left flag set");

endmodule

// ===== common/port_change_pkg.sv
package port_change_pkg;

    // ****************************************
    // Widths and positions
    // ****************************************
    localparam int          CHANGE_PIN_COUNT = 4;
    localparam int          PORT_WIDTH       = 8;
    localparam int          CHANGE_PIN_LSB   = 4;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [3:0]  SNAPSHOT_RESET   = 4'h0;
    localparam logic [7:0]  PORT_RESET       = 8'h00;

    // Interrupt vector address presented on wake with global enable set
    localparam logic [12:0] IRQ_VECTOR       = 13'h0004;

endpackage

// ===== testbench/pin_source.sv
`timescale 1ns/1ns
// Interrupt sources: levels change only after a core edge, so the synchroniser sees a clean step
module pin_source (
    input  wire logic       clk_i,
    input  wire logic [7:0] level_i,
    output logic      [7:0] pins_o
);
    always @(posedge clk_i) pins_o <= level_i;
endmodule

// ===== testbench/testbench.sv
`timescale 1ns/1ns
module testbench;
    logic        clk_i = 0, rst_n_i = 0, rd = 0, clr = 0, en = 0, gie = 0, slp = 0;
    logic [7:0]  lvl = 8'h00, dir = 8'hff, pins, port, snap;
    logic        flag, wake, jump;
    logic [12:0] vaddr;
    logic [31:0] seed = 32'h60;
    int          fail_count = 0, checks = 0;
    pin_source src (.clk_i(clk_i), .level_i(lvl), .pins_o(pins));
    port_change_interrupt dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .port_pins_i(pins), .port_dir_in_i(dir),
        .port_read_i(rd), .flag_clear_i(clr), .port_change_irq_enable_i(en), .global_irq_enable_i(gie),
        .sleeping_i(slp), .change_port_o(port), .port_change_flag_o(flag), .wake_o(wake),
        .vector_jump_o(jump), .vector_addr_o(vaddr));
    initial forever #25 clk_i = ~clk_i;
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] xs(logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    function automatic logic want_flag(logic [7:0] p, logic [7:0] s, logic [7:0] d);
        return |((p ^ s) & d & 8'hf0);
    endfunction
    task automatic chk(logic [12:0] got, logic [12:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(negedge clk_i);
    endtask
    // Read first, clear a cycle later: a same-cycle clear would lose to the old mismatch
    task automatic svc();
        rd = 1;
        cyc(1);
        rd = 0;
        clr = 1;
        cyc(1);
        clr = 0;
        cyc(1);
        snap = lvl;
    endtask
    // Read one cycle before the new level reaches the compare, so the old level is captured
    task automatic race(logic [7:0] v);
        lvl = v;
        cyc(2);
        rd = 1;
        cyc(1);
        rd = 0;
        cyc(3);
    endtask
    task automatic summarize();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        #(50 * 3000);
        fail_count++;
        summarize();
    end
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        cyc(10);
        rst_n_i = 1;
        cyc(1);
        chk(flag, 0);
        chk(port, 8'h00);
        chk(vaddr, 13'h0004);
        lvl = 8'h80;
        cyc(5);
        chk(flag, 1);
        clr = 1;
        cyc(1);
        clr = 0;
        cyc(1);
        chk(flag, 1);
        svc();
        chk(flag, 0);
        chk(port, 8'h80);
        lvl = 8'h00;
        cyc(5);
        chk(flag, 1);
        svc();
        chk(port, 8'h00);
        // One-cycle pulse that is gone before the read
        lvl = 8'h40;
        cyc(1);
        lvl = 8'h00;
        cyc(5);
        chk(flag, 1);
        svc();
        chk(flag, 0);
        lvl = 8'h40;
        cyc(5);
        chk(flag, 1);
        svc();
        race(8'hc0);
        chk(flag, 1);
        svc();
        race(8'h40);
        chk(flag, 1);
        svc();
        chk(flag, 0);
        dir = 8'h0f;
        lvl = 8'h10;
        cyc(5);
        chk(flag, 0);
        dir = 8'hff;
        cyc(3);
        chk(flag, 1);
        svc();
        en = 1;
        gie = 1;
        lvl = 8'h30;
        cyc(5);
        slp = 1;
        cyc(2);
        chk(wake, 1);
        chk(jump, 1);
        gie = 0;
        cyc(2);
        chk(wake, 1);
        chk(jump, 0);
        slp = 0;
        en = 0;
        svc();
        chk(wake, 0);
        repeat (40) begin
            seed = xs(seed);
            dir = {seed[11:8], 4'hf};
            lvl = seed[7:0];
            cyc(5);
            chk(flag, want_flag(lvl, snap, dir));
            svc();
            chk(flag, 0);
            chk(port, lvl);
        end
        summarize();
    end
endmodule
